// file: include/adr_defines.svh
// Constants of the sample-rate, interrupt and command register bank.
// Assumes a 40 MHz board clock and a host that makes byte or word accesses.
`ifndef ADR_DEFINES_SVH
`define ADR_DEFINES_SVH

`define ADR_OFF_RATE 8'h06
`define ADR_OFF_LEVEL 8'h08
`define ADR_OFF_VECTOR 8'h0a
`define ADR_OFF_SRST 8'h0c
`define ADR_OFF_TRIG 8'h0e

`define ADR_RATE_RESET 15'h0000
`define ADR_LEVEL_RESET 3'h0
`define ADR_VECTOR_RESET 8'h00
`define ADR_UPPER_ONES 8'hff
`define ADR_LEVEL_PAD 5'h00
`define ADR_UNMAPPED_READ 16'h0000
`define ADR_RATE_FLOOR 15'h007a
`define ADR_RATE_OFFSET 16'h0003
`define ADR_TRIG_SOFT 2'h0

`define ADR_CLK_KHZ 40000
`define ADR_REF_KHZ 12500

`endif

// file: include/adr_pkg.sv
// Types shared by the rate, interrupt and command register bank.
// Assumes adr_defines.svh is included by the files that need constants.
package adr_pkg;
  typedef logic [14:0] adr_rate_t;
  typedef logic [2:0] adr_level_t;
  typedef logic [7:0] adr_byte_t;
  typedef enum logic [2:0] {
    ADR_SEL_NONE,
    ADR_SEL_RATE,
    ADR_SEL_LEVEL,
    ADR_SEL_VECTOR,
    ADR_SEL_SRST,
    ADR_SEL_TRIG
  } adr_sel_t;
endpackage : adr_pkg

// file: design/adr_rate_gen.sv
// Sample tick generator driven by the rate field.
// Assumes the 40 MHz board clock; clr restarts the phase on a software reset.
`timescale 1ns/1ps
`include "adr_defines.svh"
module adr_rate_gen
  import adr_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  input wire logic clr,
  // Rate field
  input wire adr_rate_t rate,
  // Tick out
  output logic tick_r
);
  // Fractional accumulator: the period is (n+3)*3.2 clocks, not whole, so the
  // phase error is carried instead of rounding, keeping the mean rate exact.
  localparam logic [31:0] STEP = 32'(`ADR_REF_KHZ);
  localparam logic [31:0] SCALE = 32'(`ADR_CLK_KHZ);

  logic [31:0] acc_r;
  logic [31:0] acc_nxt;
  logic [15:0] divisor;
  logic [31:0] limit;

  always_comb begin
    // Below the floor the rate is fixed; floor+3 gives exactly 100 kHz
    if (rate <= `ADR_RATE_FLOOR) begin
      divisor = {1'b0, `ADR_RATE_FLOOR} + `ADR_RATE_OFFSET;
    end else begin
      divisor = {1'b0, rate} + `ADR_RATE_OFFSET;
    end
    limit = 32'(SCALE * 32'(divisor));
    acc_nxt = acc_r + STEP;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      acc_r <= 32'h0000_0000;
      tick_r <= 1'b0;
    end else if (clr) begin
      acc_r <= 32'h0000_0000;
      tick_r <= 1'b0;
    end else if (acc_nxt >= limit) begin
      // A rate cut can leave the phase past two periods; drop it to keep ticks spaced
      acc_r <= (acc_nxt - limit >= limit) ? 32'h0000_0000 : acc_nxt - limit;
      tick_r <= 1'b1;
    end else begin
      acc_r <= acc_nxt;
      tick_r <= 1'b0;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  a_floor_divisor: assert property ((rate <= `ADR_RATE_FLOOR) |-> (divisor == 16'h007d))
    else $error("rate floor divisor wrong");
  a_tick_spacing: assert property (tick_r && !clr |=> !tick_r [*2])
    else $error("sample ticks too close");
endmodule : adr_rate_gen

// file: design/adr_regs.sv
// Sample rate, interrupt level, interrupt vector and command register bank.
// Assumes host strobes come from logic on the same 40 MHz clock, one cycle each.
`timescale 1ns/1ps
`include "adr_defines.svh"
module adr_regs
  import adr_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Host register access
  input wire logic host_sel,
  input wire logic host_we,
  input wire logic [7:0] host_addr,
  input wire logic [1:0] host_be,
  input wire logic [15:0] host_wdata,
  output logic [15:0] host_rdata_r,
  output logic host_ack_r,
  // Interrupt acknowledge
  input wire logic iack_sel,
  input wire logic [2:0] iack_lvl,
  // Board side
  input wire logic irq_pending,
  input wire logic [1:0] trig_mode,
  output logic [7:1] irq_o_r,
  output logic [7:1] irq_oe_r,
  output logic soft_rst_r,
  output logic calib_start_r,
  output logic scan_start_r,
  output logic sample_tick_r,
  output adr_rate_t rate_field_r
);
  adr_rate_t sample_rate_r;
  adr_level_t irq_level_field_r;
  adr_byte_t vector_byte_field_r;
  adr_sel_t sel;
  logic wr;
  logic rd;
  logic srst_hit;
  logic [15:0] rd_val;
  logic iack_hit;

  always_comb begin
    unique case (host_addr)
      `ADR_OFF_RATE: sel = ADR_SEL_RATE;
      `ADR_OFF_LEVEL: sel = ADR_SEL_LEVEL;
      `ADR_OFF_VECTOR: sel = ADR_SEL_VECTOR;
      `ADR_OFF_SRST: sel = ADR_SEL_SRST;
      `ADR_OFF_TRIG: sel = ADR_SEL_TRIG;
      default: sel = ADR_SEL_NONE;
    endcase
  end

  assign wr = host_sel && host_we && (host_be != 2'h0);
  assign rd = host_sel && !host_we;
  // Any data, any lane: the write itself is the command
  assign srst_hit = wr && (sel == ADR_SEL_SRST);
  assign iack_hit = iack_sel && (irq_level_field_r != `ADR_LEVEL_RESET)
    && (iack_lvl == irq_level_field_r) && irq_pending;

  // Rate register: cleared by a software reset, unlike the level and vector registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sample_rate_r <= `ADR_RATE_RESET;
    end else if (srst_hit) begin
      sample_rate_r <= `ADR_RATE_RESET;
    end else if (wr && sel == ADR_SEL_RATE) begin
      if (host_be[1]) begin
        sample_rate_r[14:8] <= host_wdata[14:8];
      end
      if (host_be[0]) begin
        sample_rate_r[7:0] <= host_wdata[7:0];
      end
    end
  end

  // Level and vector survive the software reset; only the pin reset clears them
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_level_field_r <= `ADR_LEVEL_RESET;
    end else if (wr && sel == ADR_SEL_LEVEL && host_be[0]) begin
      irq_level_field_r <= host_wdata[2:0];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      vector_byte_field_r <= `ADR_VECTOR_RESET;
    end else if (wr && sel == ADR_SEL_VECTOR && host_be[0]) begin
      vector_byte_field_r <= host_wdata[7:0];
    end
  end

  always_comb begin
    unique case (sel)
      ADR_SEL_RATE: rd_val = {1'b0, sample_rate_r};
      ADR_SEL_LEVEL: rd_val = {`ADR_UPPER_ONES, `ADR_LEVEL_PAD, irq_level_field_r};
      ADR_SEL_VECTOR: rd_val = {`ADR_UPPER_ONES, vector_byte_field_r};
      default: rd_val = `ADR_UNMAPPED_READ;
    endcase
  end

  // One-cycle answer; acknowledge takes priority over a register read
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      host_rdata_r <= 16'h0000;
      host_ack_r <= 1'b0;
    end else if (iack_hit) begin
      host_rdata_r <= {`ADR_UPPER_ONES, vector_byte_field_r};
      host_ack_r <= 1'b1;
    end else begin
      host_rdata_r <= rd ? rd_val : 16'h0000;
      host_ack_r <= host_sel;
    end
  end

  // Request line follows the level field; level zero drives nothing
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_oe_r <= 7'h00;
      irq_o_r <= 7'h00;
    end else begin
      for (int n = 1; n <= 7; n++) begin
        irq_oe_r[n] <= irq_pending && (irq_level_field_r == 3'(n));
      end
      irq_o_r <= 7'h00;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      soft_rst_r <= 1'b0;
      calib_start_r <= 1'b0;
    end else begin
      soft_rst_r <= srst_hit;
      calib_start_r <= srst_hit;
    end
  end

  // Other trigger modes ignore the location; the write is dropped silently
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      scan_start_r <= 1'b0;
    end else begin
      scan_start_r <= wr && (sel == ADR_SEL_TRIG) && (trig_mode == `ADR_TRIG_SOFT);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rate_field_r <= `ADR_RATE_RESET;
    end else begin
      rate_field_r <= sample_rate_r;
    end
  end

  adr_rate_gen u_rate_gen (
    .clk(clk),
    .rstn(rstn),
    .clr(srst_hit),
    .rate(sample_rate_r),
    .tick_r(sample_tick_r)
  );

  // host must write 0x00F7 after every reset; nothing here enforces it

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  sequence s_rate_word_write;
    wr && sel == ADR_SEL_RATE && host_be == 2'h3;
  endsequence
  sequence s_srst_write;
    srst_hit;
  endsequence

  a_rate_bit_zero: assert property (rd && sel == ADR_SEL_RATE && !iack_hit
      |=> host_rdata_r[15] == 1'b0)
    else $error("rate bit 15 read as one");
  a_rate_store: assert property (s_rate_word_write
      |=> sample_rate_r == $past(host_wdata[14:0]))
    else $error("rate word write not stored");
  a_irq_level: assert property (irq_pending && irq_level_field_r != 3'h0
      |=> irq_oe_r == 7'(1 << ($past(irq_level_field_r) - 3'h1)))
    else $error("wrong request line driven");
  a_irq_off: assert property (irq_level_field_r == 3'h0 |=> irq_oe_r == 7'h00)
    else $error("request driven while disabled");
  a_level_keep: assert property (s_srst_write |=> $stable(irq_level_field_r))
    else $error("level changed by soft reset");
  a_level_read: assert property (rd && sel == ADR_SEL_LEVEL && !iack_hit
      |=> host_rdata_r[15:3] == 13'h1fe0)
    else $error("level pad bits wrong");
  a_iack_vector: assert property (iack_hit |=> host_ack_r
      && host_rdata_r == {8'hff, $past(vector_byte_field_r)})
    else $error("vector not returned on acknowledge");
  a_vector_keep: assert property (s_srst_write |=> $stable(vector_byte_field_r))
    else $error("vector changed by soft reset");
  a_srst_calib: assert property (s_srst_write
      |=> soft_rst_r && calib_start_r && sample_rate_r == 15'h0000)
    else $error("soft reset did not start calibration");
  a_trig_start: assert property (wr && sel == ADR_SEL_TRIG && trig_mode == 2'h0
      |=> scan_start_r)
    else $error("soft trigger did not start scan");
  a_trig_block: assert property (trig_mode != 2'h0 |=> !scan_start_r)
    else $error("scan started in hardware trigger mode");
  a_byte_lane: assert property (wr && sel == ADR_SEL_RATE && host_be == 2'h1
      |=> sample_rate_r[14:8] == $past(sample_rate_r[14:8]))
    else $error("byte write touched other lane");
  a_rate_copy: assert property (rate_field_r == $past(sample_rate_r))
    else $error("rate field copy wrong");
  a_ack_follow: assert property (host_sel |=> host_ack_r)
    else $error("access not acknowledged");
  a_iack_refuse: assert property (iack_sel && iack_lvl != irq_level_field_r && !host_sel
      |=> !host_ack_r)
    else $error("acknowledge answered for wrong level");
  a_level_store: assert property (wr && sel == ADR_SEL_LEVEL && host_be[0]
      |=> irq_level_field_r == $past(host_wdata[2:0]))
    else $error("level byte write not stored");
  a_vector_store: assert property (wr && sel == ADR_SEL_VECTOR && host_be[0]
      |=> vector_byte_field_r == $past(host_wdata[7:0]))
    else $error("vector byte write not stored");
endmodule : adr_regs

// file: dv/adr_host_model.sv
// Host model: single-cycle register accesses and interrupt acknowledge cycles.
// Assumes the 40 MHz board clock; strobes change 1 ns after a rising edge.
`timescale 1ns/1ps
module adr_host_model (
  // Clock
  input wire logic clk,
  // Host access
  output logic host_sel,
  output logic host_we,
  output logic [7:0] host_addr,
  output logic [1:0] host_be,
  output logic [15:0] host_wdata,
  // Interrupt acknowledge
  output logic iack_sel,
  output logic [2:0] iack_lvl
);
  initial begin
    host_sel = 1'b0;
    host_we = 1'b0;
    host_addr = 8'h00;
    host_be = 2'h0;
    host_wdata = 16'h0000;
    iack_sel = 1'b0;
    iack_lvl = 3'h0;
  end

  // Any data is written to the command locations
  task acc(input logic we, input logic [7:0] a, input logic [1:0] be, input logic [15:0] d);
    @(posedge clk);
    #1;
    host_sel = 1'b1;
    host_we = we;
    host_addr = a;
    host_be = be;
    host_wdata = d;
    @(posedge clk);
    #1;
    host_sel = 1'b0;
    // Released bus must not keep showing the last value
    host_wdata = ~d;
    host_addr = ~a;
  endtask : acc

  task iack(input logic [2:0] lvl);
    @(posedge clk);
    #1;
    iack_sel = 1'b1;
    iack_lvl = lvl;
    @(posedge clk);
    #1;
    iack_sel = 1'b0;
    iack_lvl = ~lvl;
  endtask : iack
endmodule : adr_host_model

// file: dv/testbench.sv
// Self-checking bench for the rate, interrupt and command register bank.
// Assumes the host model drives all bus inputs; answers are checked at negedge.
`timescale 1ns/1ps
`include "adr_defines.svh"
module testbench;
  import adr_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic irq_pending = 1'b0;
  logic [1:0] trig_mode = 2'h0;
  wire logic host_sel, host_we, iack_sel;
  wire logic [7:0] host_addr;
  wire logic [1:0] host_be;
  wire logic [15:0] host_wdata;
  wire logic [2:0] iack_lvl;
  logic [15:0] rdata;
  logic ack, srst, calib, scan, tick;
  logic [7:1] irq_o, irq_oe;
  adr_rate_t rate_f;
  logic [16:0] exp_q[$];
  logic [16:0] e_m;
  logic [31:0] rng = 32'h0000_004e;
  logic [31:0] d;
  logic [7:0] v;
  int err_total = 0;
  int n_tests = 0;
  int cyc = 0;

  always #12.5 clk = ~clk;

  adr_host_model host (.clk(clk), .host_sel(host_sel), .host_we(host_we),
    .host_addr(host_addr), .host_be(host_be), .host_wdata(host_wdata),
    .iack_sel(iack_sel), .iack_lvl(iack_lvl));

  adr_regs DUT (.clk(clk), .rstn(rstn), .host_sel(host_sel), .host_we(host_we),
    .host_addr(host_addr), .host_be(host_be), .host_wdata(host_wdata),
    .host_rdata_r(rdata), .host_ack_r(ack), .iack_sel(iack_sel), .iack_lvl(iack_lvl),
    .irq_pending(irq_pending), .trig_mode(trig_mode), .irq_o_r(irq_o), .irq_oe_r(irq_oe),
    .soft_rst_r(srst), .calib_start_r(calib), .scan_start_r(scan),
    .sample_tick_r(tick), .rate_field_r(rate_f));

  function logic [31:0] xs();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction : xs

  task summarize();
    if (err_total == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : summarize

  task chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      $display("Error %s expected %h seen %h", name, exp, seen);
      err_total++;
    end
  endtask : chk

  task rd(input logic [7:0] a, input logic [15:0] e);
    exp_q.push_back({1'b1, e});
    host.acc(1'b0, a, 2'h3, 16'h0000);
  endtask : rd

  task wr(input logic [7:0] a, input logic [1:0] be, input logic [15:0] wd);
    exp_q.push_back(17'h0_0000);
    host.acc(1'b1, a, be, wd);
  endtask : wr

  // Skips the first gap so a phase left from the old rate is not measured
  task gap(input logic [15:0] e);
    int n;
    n = 0;
    while (tick !== 1'b1 && n < 2000) begin
      @(posedge clk);
      #1 n++;
    end
    n = 0;
    do begin
      @(posedge clk);
      #1 n++;
    end while (tick !== 1'b1 && n < 2000);
    chk("tick gap", n[15:0], e);
  endtask : gap

  // Every answer pulse must match the oldest outstanding request
  always @(negedge clk) begin
    if (ack === 1'b1) begin
      if (exp_q.size() == 0) chk("stray ack", 16'h0001, 16'h0000);
      else begin
        e_m = exp_q.pop_front();
        if (e_m[16]) chk("rdata", rdata, e_m[15:0]);
      end
    end
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      summarize();
    end
  end

  initial begin
    repeat (3) @(posedge clk);
    #1 rstn = 1'b1;
    chk("rate copy", {1'b0, rate_f}, 16'h0000);
    rd(`ADR_OFF_RATE, 16'h0000);
    rd(`ADR_OFF_LEVEL, 16'hff00);
    rd(`ADR_OFF_VECTOR, 16'hff00);
    rd(8'h10, `ADR_UNMAPPED_READ);
    wr(`ADR_OFF_RATE, 2'h3, 16'h00f7);
    gap(16'd800);
    wr(`ADR_OFF_RATE, 2'h3, 16'h0000);
    gap(16'd400);
    wr(`ADR_OFF_RATE, 2'h3, 16'hffff);
    rd(`ADR_OFF_RATE, 16'h7fff);
    chk("rate copy", {1'b0, rate_f}, 16'h7fff);
    wr(`ADR_OFF_RATE, 2'h1, 16'h12ab);
    rd(`ADR_OFF_RATE, 16'h7fab);
    wr(`ADR_OFF_RATE, 2'h2, 16'h0000);
    rd(`ADR_OFF_RATE, 16'h00ab);
    wr(`ADR_OFF_RATE, 2'h3, 16'h007a);
    gap(16'd400);
    wr(`ADR_OFF_RATE, 2'h3, 16'h00f7);
    gap(16'd800);
    irq_pending = 1'b1;
    for (int n = 0; n < 8; n++) begin
      d = xs();
      wr(`ADR_OFF_LEVEL, 2'h3, {d[15:3], n[2:0]});
      rd(`ADR_OFF_LEVEL, {13'h1fe0, n[2:0]});
      chk("irq enable", {9'h000, irq_oe}, n == 0 ? 16'h0000 : 16'h0001 << (n - 1));
      chk("irq drive", {9'h000, irq_o}, 16'h0000);
    end
    d = xs();
    v = d[7:0];
    wr(`ADR_OFF_VECTOR, 2'h3, d[15:0]);
    rd(`ADR_OFF_VECTOR, {8'hff, v});
    exp_q.push_back({1'b1, 8'hff, v});
    host.iack(3'h7);
    host.iack(3'h3);
    irq_pending = 1'b0;
    wr(`ADR_OFF_LEVEL, 2'h0, 16'h0002);
    rd(`ADR_OFF_LEVEL, 16'hff07);
    chk("irq idle", {9'h000, irq_oe}, 16'h0000);
    d = xs();
    wr(`ADR_OFF_SRST, 2'h1, d[15:0]);
    chk("soft reset", {14'h0000, srst, calib}, 16'h0003);
    rd(`ADR_OFF_RATE, 16'h0000);
    chk("rate copy", {1'b0, rate_f}, 16'h0000);
    rd(`ADR_OFF_LEVEL, 16'hff07);
    rd(`ADR_OFF_VECTOR, {8'hff, v});
    wr(`ADR_OFF_RATE, 2'h3, 16'h00f7);
    for (int m = 0; m < 4; m++) begin
      trig_mode = m[1:0];
      d = xs();
      wr(`ADR_OFF_TRIG, 2'h2, d[15:0]);
      chk("scan start", {15'h0000, scan}, {15'h0000, m == 0});
    end
    repeat (2) @(posedge clk);
    chk("pending answers", 16'(exp_q.size()), 16'h0000);
    summarize();
  end
endmodule : testbench
